// ==== src/ptc_pkg.sv ====
package ptc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TENBASE = 8'h1A;
  localparam logic [7:0] IDX_DRVTEST = 8'h1B;
  localparam logic [7:0] IDX_EXTRA = 8'h1C;
  localparam int ADR_W = 10;
  // serial control fields
  localparam int TB_JABBER_OFF = 0;
  localparam int TB_HEARTBEAT_OFF = 1;
  localparam logic [15:0] TB_RESET = 16'h0804;
  // driver test / self-test extension fields
  localparam int DT_TALLY_LO = 8;
  localparam int DT_NONSTOP = 5;
  localparam int DT_PATTERN_ON = 4;
  localparam int DT_SPACING = 2;
  localparam int DT_CHOICE_LO = 0;
  localparam logic [7:0] DT_RW_MASK = 8'hFF;
  localparam logic [7:0] DT_RESET = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hFF;
  // extra control
  localparam int EX_RESTART = 9;
  // pattern choices
  localparam logic [1:0] PAT_DATA_END1 = 2'h0;
  localparam logic [1:0] PAT_DATA_END2 = 2'h1;
  localparam logic [1:0] PAT_LINK_PULSE = 2'h2;
  localparam logic [1:0] PAT_TONE = 2'h3;
  // timing
  localparam int CLK_NS = 10;
  localparam int GAP_SHORT_NS = 10000;
  localparam int GAP_LONG_NS = 15000;
  localparam int GAP_SHORT_CYC = (GAP_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_LONG_CYC = (GAP_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_W = 11;

  typedef enum logic [2:0] {
    PTC_IDLE = 3'h1,
    PTC_SEND = 3'h2,
    PTC_GAP = 3'h4
  } ptc_pat_state_t;

  typedef struct packed {
    logic [15:0] tenbase;
    logic [7:0] drvtest;
    logic [7:0] tally;
    logic restart;
    logic ack;
    logic [31:0] rdata;
    logic heartbeat_en;
    logic jabber_en;
    logic nonstop;
    ptc_pat_state_t pat;
    logic [GAP_W-1:0] gap_cnt;
    logic seq_start;
    logic [1:0] choice;
  } ptc_state_t;
endpackage : ptc_pkg

// ==== src/ptc_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RL1: heartbeat-off bit suppresses heartbeat, half-duplex 10Mb
// RL2: 100Mb or full duplex forces heartbeat off
// RL3: jabber-guard-off disables jabber, 10BASE-T only
// RL4: eight-bit tally counts errored self-test nibbles
// RL5: tally clears when self-test restarts
// RL6: tally saturates at maximum, never wraps
// RL7: nonstop bit sends pseudo-random data without gaps
// RL8: software sets jabber-off before 10Mb nonstop
// RL9: driver-pattern-on enables 10Mb pattern generator
// RL10: spacing bit picks 15 or 10 us gap
// RL11: choice selects end-marker data, link pulses, tone
// RL12: logic restart resets logic, keeps registers, self-clears
// RL13: reserved extra-control fields ignore writes, read zero
// RL14: software writes reserved bits to documented values
module ptc_regs
  import ptc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic speed_100_i,
  input wire logic full_duplex_i,
  input wire logic selftest_run_i,
  input wire logic selftest_restart_i,
  input wire logic selftest_nibble_err_i,
  input wire logic pattern_seq_done_i,
  output logic heartbeat_en_o,
  output logic jabber_en_o,
  output logic selftest_nonstop_o,
  output logic pattern_active_o,
  output logic pattern_seq_start_o,
  output logic [1:0] driver_pattern_choice_o,
  output logic logic_restart_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] sel
  );
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = data[7:0];
    end
    if (sel[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : lane_merge

  function automatic logic [GAP_W-1:0] gap_load(input logic long_gap);
    return long_gap ? GAP_W'(GAP_LONG_CYC - 1) : GAP_W'(GAP_SHORT_CYC - 1);
  endfunction : gap_load

  ////////////////////////////////////////////////////////////////////////////
  ptc_state_t s_reg;
  ptc_state_t s_next;

  logic req;
  logic wr_take;
  logic [7:0] idx;
  logic [15:0] merged;
  logic pat_on;
  logic half10;

  assign req = cyc_i & stb_i;
  // writes land on the edge where ack is seen, as the master expects
  assign wr_take = req & we_i & s_reg.ack;
  assign idx = adr_i[ADR_W-1:2];
  assign pat_on = s_reg.drvtest[DT_PATTERN_ON];
  assign half10 = ~speed_100_i & ~full_duplex_i;

  always_comb begin
    s_next = s_reg;
    merged = 16'h0000;
    s_next.ack = req & ~s_reg.ack;
    s_next.restart = 1'b0; // RL12
    s_next.seq_start = 1'b0;

    // read data captured with ack; unmapped reads give zero
    s_next.rdata = 32'h0000_0000;
    if (req & ~s_reg.ack & ~we_i) begin
      unique case (idx)
        IDX_TENBASE: s_next.rdata = {16'h0000, s_reg.tenbase};
        IDX_DRVTEST: s_next.rdata = {16'h0000, s_reg.tally, s_reg.drvtest}; // RL4
        IDX_EXTRA: s_next.rdata = {22'h0, s_reg.restart, 9'h000}; // RL13
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end

    // register writes; unmapped writes are acked and dropped
    if (wr_take) begin
      unique case (idx)
        IDX_TENBASE: s_next.tenbase = lane_merge(s_reg.tenbase, dat_i, sel_i);
        IDX_DRVTEST: begin
          merged = lane_merge({s_reg.tally, s_reg.drvtest}, dat_i, sel_i);
          s_next.drvtest = merged[7:0] & DT_RW_MASK; // RL4
        end
        IDX_EXTRA: begin
          if (sel_i[1]) begin
            s_next.restart = dat_i[EX_RESTART]; // RL12 RL13
          end
        end
        default: s_next.restart = 1'b0;
      endcase
    end

    // errored-nibble tally; an error beside a restart still counts
    if (selftest_restart_i) begin
      s_next.tally = 8'h00; // RL5
    end
    if (selftest_run_i & selftest_nibble_err_i) begin
      if (selftest_restart_i) begin
        s_next.tally = 8'h01;
      end else if (s_reg.tally != TALLY_MAX) begin
        s_next.tally = s_reg.tally + 8'h01; // RL4 RL6
      end
    end

    // line controls
    s_next.heartbeat_en = half10 & ~s_reg.tenbase[TB_HEARTBEAT_OFF]; // RL1 RL2
    s_next.jabber_en = ~speed_100_i & ~s_reg.tenbase[TB_JABBER_OFF]; // RL3
    // jabber must already be off at 10Mb for an unbroken stream
    s_next.nonstop = s_reg.drvtest[DT_NONSTOP]; // RL7 RL8
    s_next.choice = s_reg.drvtest[DT_CHOICE_LO +: 2]; // RL11

    // pattern sequencer
    unique case (s_reg.pat)
      PTC_IDLE: begin
        if (pat_on) begin
          s_next.pat = PTC_SEND; // RL9
          s_next.seq_start = 1'b1;
        end
      end
      PTC_SEND: begin
        // the tone runs without breaks, so it never enters the gap
        if (pattern_seq_done_i && s_reg.choice != PAT_TONE) begin
          s_next.pat = PTC_GAP;
          s_next.gap_cnt = gap_load(s_reg.drvtest[DT_SPACING]); // RL10
        end
      end
      PTC_GAP: begin
        if (s_reg.gap_cnt == '0) begin
          s_next.pat = PTC_SEND;
          s_next.seq_start = 1'b1;
        end else begin
          s_next.gap_cnt = s_reg.gap_cnt - GAP_W'(1);
        end
      end
      default: s_next.pat = PTC_IDLE;
    endcase
    if (!pat_on || s_reg.restart) begin
      s_next.pat = PTC_IDLE; // RL9 RL12
      s_next.seq_start = 1'b0;
      s_next.gap_cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg.tenbase <= TB_RESET;
      s_reg.drvtest <= DT_RESET;
      s_reg.tally <= 8'h00;
      s_reg.restart <= 1'b0;
      s_reg.ack <= 1'b0;
      s_reg.rdata <= 32'h0000_0000;
      s_reg.heartbeat_en <= 1'b0;
      s_reg.jabber_en <= 1'b0;
      s_reg.nonstop <= 1'b0;
      s_reg.pat <= PTC_IDLE;
      s_reg.gap_cnt <= '0;
      s_reg.seq_start <= 1'b0;
      s_reg.choice <= PAT_DATA_END1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign dat_o = s_reg.rdata;
  assign ack_o = s_reg.ack;
  assign heartbeat_en_o = s_reg.heartbeat_en;
  assign jabber_en_o = s_reg.jabber_en;
  assign selftest_nonstop_o = s_reg.nonstop;
  assign pattern_active_o = s_reg.pat != PTC_IDLE;
  assign pattern_seq_start_o = s_reg.seq_start;
  assign driver_pattern_choice_o = s_reg.choice;
  assign logic_restart_o = s_reg.restart;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_heartbeat_half_ten: assert property ( // RL1
    !rst_i && half10 && !s_reg.tenbase[TB_HEARTBEAT_OFF] ##1 half10 |-> heartbeat_en_o
  ) else $error("heartbeat not enabled in half-duplex 10Mb");

  a_heartbeat_forced_off: assert property ( // RL2
    (speed_100_i || full_duplex_i) |=> !heartbeat_en_o
  ) else $error("heartbeat on at 100Mb or full duplex");

  a_jabber_off_bit: assert property ( // RL3
    (speed_100_i || s_reg.tenbase[TB_JABBER_OFF]) |=> !jabber_en_o
  ) else $error("jabber active while disabled");

  a_tally_counts_up: assert property ( // RL4
    selftest_run_i && selftest_nibble_err_i && !selftest_restart_i
      && s_reg.tally != TALLY_MAX |=> s_reg.tally == $past(s_reg.tally) + 8'h01
  ) else $error("tally missed an errored nibble");

  a_tally_restart_clear: assert property ( // RL5
    selftest_restart_i && !selftest_nibble_err_i |=> s_reg.tally == 8'h00
  ) else $error("tally not cleared on restart");

  a_tally_saturates: assert property ( // RL6
    s_reg.tally == TALLY_MAX && !selftest_restart_i |=> s_reg.tally == TALLY_MAX
  ) else $error("tally wrapped past maximum");

  a_nonstop_follows: assert property ( // RL7
    $rose(s_reg.drvtest[DT_NONSTOP]) |=> selftest_nonstop_o
  ) else $error("nonstop output lags its bit");

  a_pattern_off_idle: assert property ( // RL9
    !pat_on |=> !pattern_active_o ##0 !pattern_seq_start_o
  ) else $error("pattern generator running while off");

  a_gap_load_value: assert property ( // RL10
    $rose(s_reg.pat == PTC_GAP) |-> s_reg.gap_cnt
      == gap_load($past(s_reg.drvtest[DT_SPACING]))
  ) else $error("wrong inter-sequence gap loaded");

  a_tone_no_gap: assert property ( // RL11
    s_reg.pat == PTC_SEND && s_reg.choice == PAT_TONE |=> s_reg.pat != PTC_GAP
  ) else $error("tone pattern entered a gap");

  a_restart_self_clear: assert property ( // RL12
    logic_restart_o |=> !logic_restart_o && !pattern_active_o
  ) else $error("logic restart did not self-clear");

  a_extra_reserved_zero: assert property ( // RL13
    ack_o |-> dat_o[15:10] == 6'h00 && dat_o[8:0] == 9'h000 || $past(idx) != IDX_EXTRA
  ) else $error("reserved extra-control bits read nonzero");

  a_ack_single_pulse: assert property (
    ack_o |=> !ack_o
  ) else $error("ack held longer than one cycle");

  a_heartbeat_bit_off: assert property ( // RL1
    s_reg.tenbase[TB_HEARTBEAT_OFF] |=> !heartbeat_en_o
  ) else $error("heartbeat on while its off bit is set");

  // release edge excluded: outputs still carry reset values there
  a_jabber_on_ten: assert property ( // RL3
    !rst_i && !speed_100_i && !s_reg.tenbase[TB_JABBER_OFF] |=> jabber_en_o
  ) else $error("jabber not enabled at 10Mb");

  a_tally_held_idle: assert property ( // RL4
    !selftest_run_i && !selftest_restart_i |=> $stable(s_reg.tally)
  ) else $error("tally moved without running self-test");

  a_tally_read_field: assert property ( // RL4
    ack_o && !$past(we_i) && $past(idx) == IDX_DRVTEST
      |-> dat_o[DT_TALLY_LO +: 8] == $past(s_reg.tally)
  ) else $error("tally not returned in the upper byte");

  a_tally_restart_err: assert property ( // RL5
    selftest_restart_i && selftest_run_i && selftest_nibble_err_i |=> s_reg.tally == 8'h01
  ) else $error("restart with an error did not leave tally at one");

  a_nonstop_drops: assert property ( // RL7
    $fell(s_reg.drvtest[DT_NONSTOP]) |=> !selftest_nonstop_o
  ) else $error("nonstop output stuck after its bit cleared");

  a_tone_choice_out: assert property ( // RL11
    s_reg.drvtest[DT_CHOICE_LO +: 2] == PAT_TONE |=> driver_pattern_choice_o == PAT_TONE
  ) else $error("tone selection not on the choice output");

  a_pattern_start_on: assert property ( // RL9
    !pattern_active_o && pat_on && !s_reg.restart |=> pattern_seq_start_o && pattern_active_o
  ) else $error("pattern generator did not start");

  a_start_one_cycle: assert property ( // RL9
    pattern_seq_start_o |=> !pattern_seq_start_o
  ) else $error("sequence start held longer than one cycle");

  a_done_enters_gap: assert property ( // RL10
    s_reg.pat == PTC_SEND && pattern_seq_done_i && s_reg.choice != PAT_TONE && pat_on
      && !s_reg.restart |=> s_reg.pat == PTC_GAP
  ) else $error("finished sequence not followed by a gap");

  a_gap_counts_down: assert property ( // RL10
    s_reg.pat == PTC_GAP && s_reg.gap_cnt != '0 && pat_on && !s_reg.restart
      |=> s_reg.gap_cnt == $past(s_reg.gap_cnt) - GAP_W'(1)
  ) else $error("gap counter skipped a step");

  a_gap_end_start: assert property ( // RL10
    s_reg.pat == PTC_GAP && s_reg.gap_cnt == '0 && pat_on && !s_reg.restart
      |=> pattern_seq_start_o
  ) else $error("no sequence start after the gap");

  a_restart_from_write: assert property ( // RL12
    wr_take && idx == IDX_EXTRA && sel_i[1] && dat_i[EX_RESTART] |=> logic_restart_o
  ) else $error("logic restart write gave no pulse");

  a_restart_needs_write: assert property ( // RL12
    !wr_take |=> !logic_restart_o
  ) else $error("logic restart without a write");

  a_restart_keeps_regs: assert property ( // RL12
    logic_restart_o |=> $stable(s_reg.tenbase) && $stable(s_reg.drvtest)
  ) else $error("logic restart changed register contents");

  a_extra_write_ignored: assert property ( // RL13
    wr_take && idx == IDX_EXTRA |=> $stable(s_reg.tenbase) && $stable(s_reg.drvtest)
  ) else $error("extra-control write disturbed other registers");

  a_tenbase_write_lands: assert property (
    wr_take && idx == IDX_TENBASE && sel_i == 4'h3 |=> s_reg.tenbase == 16'($past(dat_i))
  ) else $error("serial control write did not land");

  a_ack_follows_req: assert property (
    req && !ack_o |=> ack_o
  ) else $error("request not acknowledged in the next cycle");

  a_rdata_zero_idle: assert property (
    !ack_o |-> dat_o == 32'h0000_0000
  ) else $error("read data nonzero outside ack");

  a_upper_half_zero: assert property (
    ack_o |-> dat_o[31:16] == 16'h0000
  ) else $error("upper half of read data nonzero");

endmodule : ptc_regs

`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ptc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, sp_i = 1'b0, fd_i = 1'b0;
  logic run_i = 1'b0, rs_i = 1'b0, err_i = 1'b0, done_i = 1'b0;
  logic hb_o, jab_o, ns_o, act_o, start_o, restart_o;
  logic [ADR_W-1:0] adr_i = '0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [1:0] ch_o;
  logic [15:0] q;
  int bad_count = 0, n_compared = 0, pulses = 0, k;
  always #5 clk_i = ~clk_i;
  ptc_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .speed_100_i(sp_i), .full_duplex_i(fd_i), .selftest_run_i(run_i),
    .selftest_restart_i(rs_i), .selftest_nibble_err_i(err_i), .pattern_seq_done_i(done_i),
    .heartbeat_en_o(hb_o), .jabber_en_o(jab_o), .selftest_nonstop_o(ns_o),
    .pattern_active_o(act_o), .pattern_seq_start_o(start_o),
    .driver_pattern_choice_o(ch_o), .logic_restart_o(restart_o));
  always @(posedge clk_i) begin
    if (restart_o === 1'b1) pulses <= pulses + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // classic cycle; wait on ack with a bound, no assumed latency
  task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h3;
    dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o[15:0];
    if (n >= 50) bad_count++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input string nm, input logic [7:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000);
    chk(nm, {16'h0000, q}, {16'h0000, exp});
  endtask : rd
  // edges from a done pulse to the next sequence start
  task automatic gap_len(output int c);
    done_i <= 1'b1;
    c = 0;
    do begin
      @(posedge clk_i);
      done_i <= 1'b0;
      c++;
    end while (start_o !== 1'b1 && c < 3000);
  endtask : gap_len
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("tenbase_reset", IDX_TENBASE, TB_RESET);
    rd("drvtest_reset", IDX_DRVTEST, 16'h0000);
    rd("extra_reset", IDX_EXTRA, 16'h0000);
    rd("unmapped", 8'h00, 16'h0000);
    // every mix of disable bits, speed and duplex
    for (int i = 0; i < 16; i++) begin
      sp_i <= i[2];
      fd_i <= i[3];
      wb(1'b1, IDX_TENBASE, 16'h0804 | 16'(i[1:0]));
      repeat (3) @(posedge clk_i);
      chk("heartbeat_en", {31'h0, hb_o}, {31'h0, !i[1] && !i[2] && !i[3]});
      chk("jabber_en", {31'h0, jab_o}, {31'h0, !i[0] && !i[2]});
    end
    sp_i <= 1'b0;
    fd_i <= 1'b0;
    // tally: counted only while running, ro, cleared by restart, sticks at max
    run_i <= 1'b1;
    err_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    run_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    err_i <= 1'b0;
    wb(1'b1, IDX_DRVTEST, 16'hFF00);
    rd("tally_count", IDX_DRVTEST, 16'h0300);
    rs_i <= 1'b1;
    @(posedge clk_i);
    rs_i <= 1'b0;
    @(posedge clk_i);
    rd("tally_clear", IDX_DRVTEST, 16'h0000);
    // restart and error together: the error still counts
    rs_i <= 1'b1;
    run_i <= 1'b1;
    err_i <= 1'b1;
    @(posedge clk_i);
    rs_i <= 1'b0;
    run_i <= 1'b0;
    err_i <= 1'b0;
    @(posedge clk_i);
    rd("tally_set_wins", IDX_DRVTEST, 16'h0100);
    run_i <= 1'b1;
    err_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    run_i <= 1'b0;
    err_i <= 1'b0;
    rd("tally_sat", IDX_DRVTEST, {TALLY_MAX, 8'h00});
    // jabber off first, then nonstop transmit
    wb(1'b1, IDX_TENBASE, 16'h0805);
    wb(1'b1, IDX_DRVTEST, 16'h0020);
    @(posedge clk_i);
    chk("nonstop", {31'h0, ns_o}, 32'h1);
    // pattern generator and both gap lengths
    wb(1'b1, IDX_DRVTEST, 16'h0010);
    @(posedge clk_i);
    chk("pattern_active", {31'h0, act_o}, 32'h1);
    gap_len(k);
    chk("gap_short", k, GAP_SHORT_CYC + 2);
    wb(1'b1, IDX_DRVTEST, 16'h0014);
    gap_len(k);
    chk("gap_long", k, GAP_LONG_CYC + 2);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, IDX_DRVTEST, 16'h0010 | 16'(c));
      @(posedge clk_i);
      chk("choice", {30'h0, ch_o}, c);
    end
    // tone ignores a finished sequence and never gaps
    done_i <= 1'b1;
    @(posedge clk_i);
    done_i <= 1'b0;
    @(posedge clk_i);
    // restart pulse: sequencer idles, registers kept, bit self-clears
    wb(1'b1, IDX_EXTRA, 16'hFFFF);
    @(posedge clk_i);
    chk("pattern_idle", {31'h0, act_o}, 32'h0);
    @(posedge clk_i);
    chk("restart_pulses", pulses, 1);
    rd("tenbase_kept", IDX_TENBASE, 16'h0805);
    rd("drvtest_kept", IDX_DRVTEST, {TALLY_MAX, 8'h13});
    rd("extra_zero", IDX_EXTRA, 16'h0000);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
